// ===== rtl/rxs_ctrl.sv
// Receive status word builder, receive FIFOs and receiver halt control
// Operation
// - Reserved status bits always read zero
// - Filter fail flag on failed address match
// - Length field holds frame byte count
// - Error summary is OR of four errors
// - Broadcast flag on broadcast destination
// - Length mismatch flag against length/type
// - Runt flag below 64 bytes
// - Runts kept only when pass-bad set
// - Multicast flag on multicast destination
// - Too-long flag above 1518, no truncation
// - Late collision flag after window
// - Type flag above 1500, not short runts
// - Watchdog flag beyond 2048 bytes
// - Media error flag on any rx error
// - Dribble with 4 bits, or 3 or more in 10 Mbps mode
// - No dribble flag with late collision
// - CRC flag on mismatch or rx error
// - One pulse when receiver has halted
// - Receiver error on underrun or status overrun
// - Receiver keeps running after error
// - Status queued after frame data
//
// The register addresses and the AHB-Lite interface to the registers were left to the implementer.
`timescale 1ns/10ps
module rxs_ctrl
    import rxs_pkg::*;
#(
    parameter int DAW = 9, // Data FIFO address width (words)
    parameter int SAW = 4 // Status FIFO address width
) (
    input wire logic sys_clk_in, // 20 MHz clock
    input wire logic sys_rst_in, // Synchronous reset, high
    input wire logic hsel_in, // AHB select
    input wire logic [31:0] haddr_in, // AHB address
    input wire logic [1:0] htrans_in, // AHB transfer type
    input wire logic hwrite_in, // AHB write
    input wire logic [2:0] hsize_in, // AHB size
    input wire logic [31:0] hwdata_in, // AHB write data
    input wire logic hready_in, // AHB bus ready
    output logic [31:0] hrdata_out, // AHB read data
    output logic hreadyout_out, // AHB slave ready
    output logic hresp_out, // AHB response
    input wire logic mil_valid_in, // Frame byte valid
    input wire logic [7:0] mil_byte_in, // Frame byte
    input wire logic mil_last_in, // Last byte of frame
    input wire logic mil_rx_er_in, // Media receive error
    input wire logic mil_coll_in, // Collision seen
    input wire logic mil_filt_fail_in, // Address filter failed, at last
    input wire logic mil_crc_bad_in, // CRC mismatch, at last
    input wire logic [2:0] mil_drib_in, // Dribble bits, at last
    input wire logic mil_10m_in, // 10 Mbps mode
    output logic receiver_halted_interrupt_out, // One-cycle halt pulse
    output logic receiver_error_flag_out // Sticky receiver error
);
    import rxs_pkg::*;

    function automatic logic [15:0] fill(input logic [15:0] w, input logic [15:0] r);
        fill = w - r;
    endfunction : fill

    // ****************************************
    // Bus slave and registers
    // ****************************************
    logic [31:0] ctrl_q;
    logic rxe_q;
    logic wr_ph_q;
    logic [7:0] wa_q;
    logic [31:0] hrdata_q;
    logic flush;
    logic dat_rd, sts_rd;
    logic dat_under, sts_under, sts_over;
    rxs_state_t st_q;
    logic [DAW:0] wr_q, cmt_q, rd_q;
    logic [SAW:0] swr_q, srd_q;
    logic [31:0] dmem [2**DAW];
    logic [31:0] smem [2**SAW];
    logic dat_empty, sts_empty, sts_full, dat_full;
    logic addr_ok, rd_acc;
    logic [7:0] ra;

    assign addr_ok = hsel_in && hready_in && htrans_in[1];
    assign rd_acc = addr_ok && !hwrite_in;
    assign ra = haddr_in[7:0];
    assign dat_empty = (cmt_q == rd_q);
    assign sts_empty = (swr_q == srd_q);
    assign sts_full = (swr_q[SAW] != srd_q[SAW]) && (swr_q[SAW-1:0] == srd_q[SAW-1:0]);
    assign dat_full = (wr_q[DAW] != rd_q[DAW]) && (wr_q[DAW-1:0] == rd_q[DAW-1:0]);
    assign dat_rd = rd_acc && (ra == RXS_OFF_DATA) && (haddr_in[31:8] == 24'h0);
    assign sts_rd = rd_acc && (ra == RXS_OFF_STS) && (haddr_in[31:8] == 24'h0);
    assign dat_under = dat_rd && dat_empty;
    assign sts_under = sts_rd && sts_empty;
    assign flush = wr_ph_q && (wa_q == RXS_OFF_FLUSH) && hwdata_in[0] && (st_q == RXS_HALT);
    assign hreadyout_out = 1'b1;
    assign hresp_out = 1'b0;
    assign hrdata_out = hrdata_q;
    assign receiver_error_flag_out = rxe_q;

    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            wr_ph_q <= 1'b0;
            wa_q <= 8'h00;
        end else begin
            wr_ph_q <= addr_ok && hwrite_in && (haddr_in[31:8] == 24'h0);
            wa_q <= ra;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            ctrl_q <= RXS_CTRL_RST;
        end else if (wr_ph_q && wa_q == RXS_OFF_CTRL) begin
            ctrl_q <= hwdata_in;
        end
    end

    // Read data is prepared at the address phase and stands in the data phase
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            hrdata_q <= 32'h0;
        end else if (rd_acc) begin
            if (haddr_in[31:8] != 24'h0) begin
                hrdata_q <= 32'h0;
            end else if (ra == RXS_OFF_CTRL) begin
                hrdata_q <= ctrl_q;
            end else if (ra == RXS_OFF_STAT) begin
                hrdata_q <= {30'h0, st_q == RXS_HALT, rxe_q};
            end else if (ra == RXS_OFF_DATA) begin
                hrdata_q <= dat_empty ? 32'h0 : dmem[rd_q[DAW-1:0]];
            end else if (ra == RXS_OFF_STS) begin
                hrdata_q <= sts_empty ? 32'h0 : smem[srd_q[SAW-1:0]];
            end else if (ra == RXS_OFF_INF) begin
                hrdata_q <= {fill(16'(swr_q), 16'(srd_q)), fill(16'(cmt_q), 16'(rd_q))};
            end else begin
                hrdata_q <= 32'h0;
            end
        end
    end

    // Set wins over the write-one clear; the receiver is never stopped by it
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            rxe_q <= 1'b0;
        end else if (dat_under || sts_under || sts_over) begin
            rxe_q <= 1'b1;
        end else if (wr_ph_q && wa_q == RXS_OFF_STAT && hwdata_in[RXS_STAT_RX_ERR]) begin
            rxe_q <= 1'b0;
        end
    end

    // ****************************************
    // Frame tracking
    // ****************************************
    logic in_fr_q, skip_q, fin_q, ovf_q;
    logic acc, first;
    logic [13:0] cnt_q, cnt_n;
    logic [15:0] lt_q;
    logic bc_q, mc_q, er_q, lcol_q, ff_q, crc_q;
    logic [2:0] drib_q;
    logic [31:0] pack_q;
    logic [1:0] lane_q;
    logic [31:0] word_n;
    logic push_w;

    assign first = mil_valid_in && !in_fr_q;
    assign acc = mil_valid_in && !skip_q && (in_fr_q || st_q == RXS_RUN);
    assign cnt_n = (cnt_q == 14'h3fff) ? cnt_q : cnt_q + 14'd1;

    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            in_fr_q <= 1'b0;
            skip_q <= 1'b0;
            fin_q <= 1'b0;
        end else begin
            fin_q <= acc && mil_last_in;
            if (acc) begin
                in_fr_q <= !mil_last_in;
            end
            if (mil_valid_in && !acc) begin
                skip_q <= !mil_last_in;
            end
        end
    end

    // Per-frame counters and flags, restarted on the first byte; filter fail, CRC and dribble loaded with the last byte
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            cnt_q <= 14'h0;
            lt_q <= 16'h0;
            bc_q <= 1'b0;
            mc_q <= 1'b0;
            er_q <= 1'b0;
            lcol_q <= 1'b0;
            ff_q <= 1'b0;
            crc_q <= 1'b0;
            drib_q <= 3'h0;
        end else if (acc) begin
            cnt_q <= first ? 14'd1 : cnt_n;
            if (first) begin
                mc_q <= mil_byte_in[0];
                bc_q <= (mil_byte_in == 8'hff);
                er_q <= mil_rx_er_in;
                lcol_q <= 1'b0;
                lt_q <= 16'h0;
            end else begin
                if (cnt_q < 14'd6) begin
                    bc_q <= bc_q && (mil_byte_in == 8'hff);
                end
                if (cnt_q == 14'd12) begin
                    lt_q[15:8] <= mil_byte_in;
                end
                if (cnt_q == 14'd13) begin
                    lt_q[7:0] <= mil_byte_in;
                end
                er_q <= er_q || mil_rx_er_in;
                lcol_q <= lcol_q || (mil_coll_in && cnt_q >= RXS_RUNT_LEN);
            end
            if (mil_last_in) begin
                ff_q <= mil_filt_fail_in;
                crc_q <= mil_crc_bad_in;
                drib_q <= mil_drib_in;
            end
        end
    end

    // ****************************************
    // Status word
    // ****************************************
    logic runt, lng, lcol, ftype, wdog, lenerr, drib, crc, es;
    logic [31:0] sword;

    assign runt = cnt_q < RXS_RUNT_LEN;
    assign lng = cnt_q > RXS_MAX_LEN;
    assign wdog = cnt_q > RXS_WDOG_LEN;
    assign lcol = lcol_q;
    assign ftype = (lt_q > RXS_TYPE_MIN) && (cnt_q >= RXS_HDR_LEN);
    assign lenerr = !ftype && !runt
        && ((lt_q < 16'(RXS_MIN_PAYLOAD)) ? (cnt_q != RXS_RUNT_LEN)
            : (16'(cnt_q) != lt_q + 16'(RXS_OVH_LEN)));
    assign drib = !lcol && (mil_10m_in ? (drib_q >= RXS_DRIB_10M)
        : (drib_q == RXS_DRIB_MII));
    assign crc = crc_q || er_q;
    assign es = runt || lng || lcol || crc;

    always_comb begin
        sword = 32'h0;
        sword[RXS_SW_FFAIL] = ff_q;
        sword[RXS_SW_LEN_LO +: 14] = cnt_q;
        sword[RXS_SW_ERR_SUM] = es;
        sword[RXS_SW_BCAST] = bc_q;
        sword[RXS_SW_LENERR] = lenerr;
        sword[RXS_SW_RUNT] = runt;
        sword[RXS_SW_MCAST] = mc_q && !bc_q;
        sword[RXS_SW_LONG] = lng;
        sword[RXS_SW_LCOL] = lcol;
        sword[RXS_SW_TYPE] = ftype;
        sword[RXS_SW_WDOG] = wdog;
        sword[RXS_SW_MIIERR] = er_q;
        sword[RXS_SW_DRIB] = drib;
        sword[RXS_SW_CRC] = crc;
    end

    // ****************************************
    // Data FIFO write side
    // ****************************************
    logic keep, sts_push;

    assign word_n = pack_q | ({24'h0, mil_byte_in} << {lane_q, 3'b000});
    assign push_w = acc && (lane_q == 2'd3 || mil_last_in);
    assign keep = !ovf_q && (!runt || ctrl_q[RXS_CTRL_PASSBAD]);
    assign sts_push = fin_q && keep && !sts_full;
    assign sts_over = fin_q && keep && sts_full;

    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            pack_q <= 32'h0;
            lane_q <= 2'd0;
        end else if (acc) begin
            pack_q <= push_w ? 32'h0 : word_n;
            lane_q <= mil_last_in ? 2'd0 : lane_q + 2'd1;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (push_w && !dat_full) begin
            dmem[wr_q[DAW-1:0]] <= word_n;
        end
        if (sts_push) begin
            smem[swr_q[SAW-1:0]] <= sword;
        end
    end

    // Whole frame is kept or dropped; dropped frames rewind to the commit point
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in || flush) begin
            wr_q <= '0;
            cmt_q <= '0;
            ovf_q <= 1'b0;
        end else begin
            if (fin_q) begin
                wr_q <= keep ? wr_q : cmt_q;
                cmt_q <= keep ? wr_q : cmt_q;
                ovf_q <= 1'b0;
            end else if (push_w) begin
                if (dat_full) begin
                    ovf_q <= 1'b1;
                end else begin
                    wr_q <= wr_q + 1'b1;
                end
            end
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in || flush) begin
            rd_q <= '0;
            swr_q <= '0;
            srd_q <= '0;
        end else begin
            if (dat_rd && !dat_empty) begin
                rd_q <= rd_q + 1'b1;
            end
            if (sts_rd && !sts_empty) begin
                srd_q <= srd_q + 1'b1;
            end
            if (sts_push) begin
                swr_q <= swr_q + 1'b1;
            end
        end
    end

    // ****************************************
    // Receiver run and halt control
    // ****************************************
    logic halt_q;

    assign receiver_halted_interrupt_out = halt_q;

    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            st_q <= RXS_HALT;
            halt_q <= 1'b0;
        end else begin
            halt_q <= 1'b0;
            case (st_q)
                RXS_HALT: begin
                    if (ctrl_q[RXS_CTRL_RX_ENABLE]) begin
                        st_q <= RXS_RUN;
                    end
                end
                RXS_RUN: begin
                    if (!ctrl_q[RXS_CTRL_RX_ENABLE]) begin
                        st_q <= RXS_DRAIN;
                    end
                end
                default: begin
                    if (!in_fr_q && !fin_q && !acc) begin
                        st_q <= RXS_HALT;
                        halt_q <= 1'b1;
                    end
                end
            endcase
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    a_rsvd_zero: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        sts_push |-> (sword[31] == 1'b0 && sword[14] == 1'b0 && sword[9:8] == 2'b00
            && sword[0] == 1'b0))
        else $error("reserved status bit set");
    a_es_sum: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        sts_push |-> sword[15] == (sword[11] | sword[7] | sword[6] | sword[1]))
        else $error("error summary mismatch");
    a_len_field: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        (acc && mil_last_in && in_fr_q && cnt_q == 14'd99) |=> sword[29:16] == 14'd100)
        else $error("length field wrong");
    a_drib_coll: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        sts_push && sword[6] |-> !sword[2])
        else $error("dribble with late collision");
    a_crc_rxer: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        sts_push && sword[3] |-> sword[1])
        else $error("crc flag missing on rx error");
    a_runt_drop: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        (fin_q && cnt_q < RXS_RUNT_LEN && !ctrl_q[RXS_CTRL_PASSBAD] && !flush)
            |=> $stable(swr_q) && wr_q == $past(cmt_q))
        else $error("runt kept without pass-bad");
    a_sts_after: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        (swr_q != $past(swr_q) && !$past(flush)) |-> $past(fin_q) && !$past(push_w))
        else $error("status queued before data");
    a_halt_pulse: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        halt_q |-> st_q == RXS_HALT && !in_fr_q ##1 !halt_q)
        else $error("halt pulse wrong");
    a_rxe_under: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        (dat_rd && dat_empty) |=> rxe_q && $stable(st_q))
        else $error("underrun not flagged");
    a_long_flag: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        sts_push && sword[29:16] > RXS_MAX_LEN |-> sword[7])
        else $error("too long flag missing");

    c_sts_push: cover property (@(posedge sys_clk_in) sts_push);
    c_halted: cover property (@(posedge sys_clk_in) halt_q);
    c_runt_drop: cover property (@(posedge sys_clk_in) fin_q && !keep);
    c_rxe_set: cover property (@(posedge sys_clk_in) $rose(rxe_q));
endmodule : rxs_ctrl

// ===== rtl/rxs_pkg.sv
// Package with register map, status word layout and frame limits for the receive status block
package rxs_pkg;
    // ****************************************
    // Register byte offsets
    // ****************************************
    localparam logic [7:0] RXS_OFF_CTRL = 8'h00;
    localparam logic [7:0] RXS_OFF_STAT = 8'h04;
    localparam logic [7:0] RXS_OFF_DATA = 8'h08;
    localparam logic [7:0] RXS_OFF_STS = 8'h0c;
    localparam logic [7:0] RXS_OFF_INF = 8'h10;
    localparam logic [7:0] RXS_OFF_FLUSH = 8'h14;
    // ****************************************
    // Control and status bit positions
    // ****************************************
    localparam int RXS_CTRL_RX_ENABLE = 2;
    localparam int RXS_CTRL_PASSBAD = 16;
    localparam int RXS_STAT_RX_ERR = 0;
    localparam int RXS_STAT_HALTED = 1;
    localparam logic [31:0] RXS_CTRL_RST = 32'h0000_0000;
    // ****************************************
    // Status word fields
    // ****************************************
    localparam int RXS_SW_FFAIL = 30;
    localparam int RXS_SW_LEN_LO = 16;
    localparam int RXS_SW_ERR_SUM = 15;
    localparam int RXS_SW_BCAST = 13;
    localparam int RXS_SW_LENERR = 12;
    localparam int RXS_SW_RUNT = 11;
    localparam int RXS_SW_MCAST = 10;
    localparam int RXS_SW_LONG = 7;
    localparam int RXS_SW_LCOL = 6;
    localparam int RXS_SW_TYPE = 5;
    localparam int RXS_SW_WDOG = 4;
    localparam int RXS_SW_MIIERR = 3;
    localparam int RXS_SW_DRIB = 2;
    localparam int RXS_SW_CRC = 1;
    // ****************************************
    // Frame limits in bytes and dribble bit counts
    // ****************************************
    localparam logic [13:0] RXS_RUNT_LEN = 14'd64;
    localparam logic [13:0] RXS_MAX_LEN = 14'd1518;
    localparam logic [13:0] RXS_WDOG_LEN = 14'd2048;
    localparam logic [13:0] RXS_HDR_LEN = 14'd14;
    localparam logic [13:0] RXS_OVH_LEN = 14'd18;
    localparam logic [13:0] RXS_MIN_PAYLOAD = 14'd46;
    localparam logic [15:0] RXS_TYPE_MIN = 16'd1500;
    localparam logic [2:0] RXS_DRIB_MII = 3'd4;
    localparam logic [2:0] RXS_DRIB_10M = 3'd3;
    typedef enum logic [1:0] {RXS_HALT, RXS_RUN, RXS_DRAIN} rxs_state_t;
endpackage : rxs_pkg

// ===== dv/rxs_mil_model.sv
// Frame source standing in for the MAC interface layer feeding the receive block
`timescale 1ns/10ps
module rxs_mil_model (
    input wire logic clk_in, // Bench clock
    output logic valid_out, // Frame byte valid
    output logic [7:0] byte_out, // Frame byte
    output logic last_out, // Last byte of frame
    output logic rx_er_out, // Media receive error
    output logic coll_out, // Collision seen
    output logic filt_fail_out, // Address filter failed
    output logic crc_bad_out, // CRC mismatch
    output logic [2:0] drib_out // Dribble bit count
);
    initial begin
        valid_out = 1'b0;
        byte_out = 8'h00;
        last_out = 1'b0;
        rx_er_out = 1'b0;
        coll_out = 1'b0;
        filt_fail_out = 1'b0;
        crc_bad_out = 1'b0;
        drib_out = 3'h0;
    end
    // ****************************************
    // One frame, optional idle gap between bytes
    // ****************************************
    task automatic send_frame(input int len, input logic [7:0] d0, input logic [15:0] lt,
        input logic ff, input logic crc, input logic rxer, input int coll_at,
        input logic [2:0] drib, input int gap);
        logic [7:0] b;
        logic lst;
        b = 8'h00;
        for (int i = 0; i < len; i++) begin
            if (i == 0) b = d0;
            else if (i < 6) b = (d0 == 8'hff) ? 8'hff : 8'h00;
            else if (i == 12) b = lt[15:8];
            else if (i == 13) b = lt[7:0];
            else b = i[7:0];
            lst = (i == len - 1);
            @(posedge clk_in);
            valid_out <= 1'b1;
            byte_out <= b;
            last_out <= lst;
            rx_er_out <= rxer && (i == len / 2);
            coll_out <= (i == coll_at);
            // End-of-frame qualifiers are only meaningful with the last byte
            filt_fail_out <= lst ? ff : ~ff;
            crc_bad_out <= lst ? crc : ~crc;
            drib_out <= lst ? drib : ~drib;
            for (int g = 0; g < gap && !lst; g++) begin
                @(posedge clk_in);
                valid_out <= 1'b0;
                byte_out <= ~b;
            end
        end
        // Idle after the frame keeps the required gap before the next one
        @(posedge clk_in);
        valid_out <= 1'b0;
        last_out <= 1'b0;
        byte_out <= ~b;
        coll_out <= 1'b0;
        rx_er_out <= 1'b0;
    endtask : send_frame
endmodule : rxs_mil_model

// ===== dv/tb_top.sv
// Self-checking bench for the receive status block over AHB-Lite
`timescale 1ns/10ps
module tb_top;
    import rxs_pkg::*;
    localparam logic [31:0] FF = 32'h4000_0000, BC = 32'h0000_2000, LM = 32'h0000_1000;
    localparam logic [31:0] RU = 32'h0000_0800, MC = 32'h0000_0400, TL = 32'h0000_0080;
    localparam logic [31:0] LC = 32'h0000_0040, TY = 32'h0000_0020, WD = 32'h0000_0010;
    localparam logic [31:0] ME = 32'h0000_0008, DR = 32'h0000_0004, CE = 32'h0000_0002;
    localparam logic [31:0] EN = 32'h0000_0001 << RXS_CTRL_RX_ENABLE;
    localparam logic [31:0] PB = 32'h0000_0001 << RXS_CTRL_PASSBAD;
    logic sys_clk_in, sys_rst_in, hsel, hwrite, m10, hresp, halt_pulse, rx_err;
    logic [31:0] haddr, hwdata, hrdata, r;
    logic [1:0] htrans;
    logic [2:0] hsize, drib;
    wire logic hready;
    logic valid, last, rxer, coll, filt, crcb;
    logic [7:0] mbyte;
    int errors = 0, total_checks = 0, pulses = 0;
    rxs_mil_model i_mil (.clk_in(sys_clk_in), .valid_out(valid), .byte_out(mbyte),
        .last_out(last), .rx_er_out(rxer), .coll_out(coll), .filt_fail_out(filt),
        .crc_bad_out(crcb), .drib_out(drib));
    rxs_ctrl #(.DAW(11), .SAW(4)) i_dut (.sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in),
        .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite),
        .hsize_in(hsize), .hwdata_in(hwdata), .hready_in(hready), .hrdata_out(hrdata),
        .hreadyout_out(hready), .hresp_out(hresp), .mil_valid_in(valid), .mil_byte_in(mbyte),
        .mil_last_in(last), .mil_rx_er_in(rxer), .mil_coll_in(coll), .mil_filt_fail_in(filt),
        .mil_crc_bad_in(crcb), .mil_drib_in(drib), .mil_10m_in(m10),
        .receiver_halted_interrupt_out(halt_pulse), .receiver_error_flag_out(rx_err));
    initial begin
        sys_clk_in = 1'b0;
        forever #25 sys_clk_in = ~sys_clk_in;
    end
    always @(posedge sys_clk_in) if (halt_pulse === 1'b1) pulses++;
    // ****************************************
    // Bus and check helpers
    // ****************************************
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            $display("unexpected %s: expected %h seen %h", nm, exp, got);
            errors++;
        end
    endtask : chk
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd,
        output logic [31:0] rd);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {24'h0, a};
        hwrite <= w;
        @(posedge sys_clk_in);
        while (hready !== 1'b1) @(posedge sys_clk_in);
        htrans <= 2'b00;
        hsel <= 1'b0;
        hwdata <= wd;
        @(posedge sys_clk_in);
        while (hready !== 1'b1) @(posedge sys_clk_in);
        rd = hrdata;
    endtask : ahb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        ahb(1'b1, a, d, x);
    endtask : wr
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string nm);
        logic [31:0] x;
        ahb(1'b0, a, 32'h0, x);
        chk(nm, exp, x);
    endtask : rd_chk
    task automatic wait_sts(input logic [15:0] n);
        logic [31:0] x;
        x = 32'h0;
        for (int k = 0; k < 100; k++) begin
            ahb(1'b0, RXS_OFF_INF, 32'h0, x);
            if (x[31:16] === n) break;
        end
        chk("status_count", {16'h0, n}, {16'h0, x[31:16]});
    endtask : wait_sts
    function automatic logic [31:0] sw(input int len, input logic [31:0] f);
        logic [31:0] w;
        w = f;
        w[29:16] = len[13:0];
        w[15] = |(f & 32'h0000_08c2);
        return w;
    endfunction : sw
    task automatic frm(input int len, input logic [7:0] d0, input logic [15:0] lt,
        input logic ff, input logic crc, input logic rxer, input int coll,
        input logic [2:0] dr, input int gap, input logic [31:0] f);
        i_mil.send_frame(len, d0, lt, ff, crc, rxer, coll, dr, gap);
        wait_sts(16'h1);
        rd_chk(RXS_OFF_STS, sw(len, f), "status_word");
    endtask : frm
    task automatic wrap_up;
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : wrap_up
    initial begin
        repeat (40000) @(posedge sys_clk_in);
        errors++;
        wrap_up();
    end
    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        sys_rst_in = 1'b1;
        {hsel, hwrite, m10} = 3'b000;
        haddr = 32'h0;
        hwdata = 32'h0;
        htrans = 2'b00;
        hsize = 3'b010;
        repeat (3) @(posedge sys_clk_in);
        sys_rst_in <= 1'b0;
        rd_chk(RXS_OFF_CTRL, RXS_CTRL_RST, "ctrl_reset");
        rd_chk(RXS_OFF_STAT, 32'h2, "stat_reset");
        rd_chk(8'h20, 32'h0, "unmapped");
        wr(RXS_OFF_CTRL, EN);
        rd_chk(RXS_OFF_CTRL, EN, "ctrl_rw");
        i_mil.send_frame(64, 8'h02, 16'd100, 1'b0, 1'b1, 1'b0, -1, 3'h0, 0);
        // Status is queued one edge after the frame ends
        repeat (2) @(posedge sys_clk_in);
        chk("hresp", 32'h0, {31'h0, hresp});
        rd_chk(RXS_OFF_INF, {16'h1, 16'h10}, "info_after_frame");
        rd_chk(RXS_OFF_STS, sw(64, LM | CE), "status_lm_crc");
        rd_chk(RXS_OFF_DATA, 32'h0000_0002, "data_word0");
        rd_chk(RXS_OFF_DATA, 32'h0706_0000, "data_word1");
        frm(64, 8'hff, 16'h0800, 1'b1, 1'b0, 1'b0, -1, 3'h0, 2, FF | BC | TY);
        frm(64, 8'h01, 16'd46, 1'b0, 1'b0, 1'b1, -1, 3'h0, 0, MC | ME | CE);
        for (int k = 0; k < 5; k++) begin
            m10 <= (k == 2 || k == 3);
            frm(70, 8'h02, 16'h0800, 1'b0, 1'b0, 1'b0, (k == 4) ? 65 : -1,
                (k == 1 || k == 2) ? 3'h3 : ((k == 3) ? 3'h2 : 3'h4), 0,
                TY | ((k == 0 || k == 2) ? DR : 32'h0) | ((k == 4) ? LC : 32'h0));
        end
        i_mil.send_frame(20, 8'h02, 16'h0800, 1'b0, 1'b0, 1'b0, -1, 3'h0, 0);
        repeat (5) @(posedge sys_clk_in);
        rd_chk(RXS_OFF_INF, 32'h0000_0088, "runt_dropped");
        wr(RXS_OFF_CTRL, EN | PB);
        frm(20, 8'h02, 16'h0800, 1'b0, 1'b0, 1'b0, -1, 3'h0, 0, RU | TY);
        frm(10, 8'h02, 16'h0800, 1'b0, 1'b0, 1'b0, -1, 3'h0, 0, RU);
        rd_chk(RXS_OFF_STS, 32'h0, "status_underrun");
        rd_chk(RXS_OFF_STAT, 32'h1, "rxe_set");
        frm(64, 8'h02, 16'h0800, 1'b0, 1'b0, 1'b0, -1, 3'h0, 1, TY);
        wr(RXS_OFF_STAT, 32'h1);
        rd_chk(RXS_OFF_STAT, 32'h0, "rxe_cleared");
        frm(1519, 8'h02, 16'h0800, 1'b0, 1'b0, 1'b0, -1, 3'h0, 0, TL | TY);
        frm(2049, 8'h02, 16'h0800, 1'b0, 1'b0, 1'b0, -1, 3'h0, 0, TL | TY | WD);
        fork
            i_mil.send_frame(100, 8'h02, 16'h0800, 1'b0, 1'b0, 1'b0, -1, 3'h0, 0);
            begin
                repeat (20) @(posedge sys_clk_in);
                wr(RXS_OFF_CTRL, PB);
                rd_chk(RXS_OFF_STAT, 32'h0, "still_draining");
            end
        join
        for (int k = 0; k < 50 && pulses == 0; k++) @(posedge sys_clk_in);
        repeat (3) @(posedge sys_clk_in);
        chk("halt_pulses", 32'h1, pulses);
        rd_chk(RXS_OFF_STAT, 32'h2, "halted");
        rd_chk(RXS_OFF_STS, sw(100, TY), "last_frame_status");
        i_mil.send_frame(64, 8'h02, 16'h0800, 1'b0, 1'b0, 1'b0, -1, 3'h0, 0);
        repeat (5) @(posedge sys_clk_in);
        ahb(1'b0, RXS_OFF_INF, 32'h0, r);
        chk("halted_ignores", 32'h0, {16'h0, r[31:16]});
        wr(RXS_OFF_FLUSH, 32'h1);
        rd_chk(RXS_OFF_INF, 32'h0, "flushed");
        rd_chk(RXS_OFF_DATA, 32'h0, "data_underrun");
        rd_chk(RXS_OFF_STAT, 32'h3, "rxe_data");
        wr(RXS_OFF_STAT, 32'h1);
        wr(RXS_OFF_CTRL, EN);
        for (int k = 0; k < 17; k++) begin
            i_mil.send_frame(64, 8'h02, 16'h0800, 1'b0, 1'b0, 1'b0, -1, 3'h0, 0);
        end
        repeat (3) @(posedge sys_clk_in);
        chk("rxe_port", 32'h1, {31'h0, rx_err});
        rd_chk(RXS_OFF_STAT, 32'h1, "rxe_overrun");
        ahb(1'b0, RXS_OFF_INF, 32'h0, r);
        chk("status_full", 32'h10, {16'h0, r[31:16]});
        wrap_up();
    end
endmodule : tb_top
